/* File: reset_circuit_model.sv */
// Model of the external reset circuit: measures overflow and chip reset pulses.
// Assumes both pulses are synchronous to clk.
`timescale 1ns/1ps
module reset_circuit_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pulses from the timer
  input  wire logic       watchdog_overflow_out_n,
  input  wire logic       chip_reset_out,
  // Measured results
  output logic      [7:0] ovf_len,
  output logic      [7:0] rst_len,
  output logic      [7:0] rst_count
);
  logic [7:0] lo_run; // Running low count
  logic [7:0] hi_run; // Running high count

  // Length of the last finished pulse of each kind
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_run    <= 8'h00;
      hi_run    <= 8'h00;
      ovf_len   <= 8'h00;
      rst_len   <= 8'h00;
      rst_count <= 8'h00;
    end else begin
      lo_run <= watchdog_overflow_out_n ? 8'h00 : lo_run + 8'h01;
      hi_run <= chip_reset_out ? hi_run + 8'h01 : 8'h00;
      if (watchdog_overflow_out_n && lo_run != 8'h00) begin
        ovf_len <= lo_run;
      end
      if (!chip_reset_out && hi_run != 8'h00) begin
        rst_len   <= hi_run;
        rst_count <= rst_count + 8'h01;
      end
    end
  end
endmodule // reset_circuit_model

/* File: tb.sv */
// Testbench for the watchdog/interval timer, driven by keyed word writes and byte reads.
// Assumes the bound checker and the reset circuit model beside the timer.
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Signals and counters
  // ****************************************
  logic        clk;
  logic        rst;
  logic        standby;
  logic [27:0] bus_addr;
  logic [1:0]  bus_size;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_wdata;
  logic [7:0]  bus_rdata;
  logic        interval_irq;
  logic        watchdog_overflow_out_n;
  logic        chip_reset_out;
  logic        chip_reset_manual;
  logic [7:0]  ovf_len;
  logic [7:0]  rst_len;
  logic [7:0]  rst_count;
  logic [7:0]  q;
  logic [7:0]  rc;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          i;
  int          k;
  int          div[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  localparam logic [27:0] ctl_wr = wdt_pkg::CTL_WR_ADDR;
  localparam logic [27:0] ctl_rd = wdt_pkg::CTL_RD_ADDR;
  localparam logic [27:0] cnt_rd = wdt_pkg::CNT_RD_ADDR;
  localparam logic [27:0] rsc_wr = wdt_pkg::RSC_WR_ADDR;
  localparam logic [27:0] rsc_rd = wdt_pkg::RSC_RD_ADDR;

  watchdog_interval_timer #(.OVF_CYCLES(4), .RST_CYCLES(8)) watchdog_interval_timer_i (
    .clk(clk), .rst(rst), .standby(standby), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .interval_irq(interval_irq),
    .watchdog_overflow_out_n(watchdog_overflow_out_n), .chip_reset_out(chip_reset_out),
    .chip_reset_manual(chip_reset_manual));
  reset_circuit_model reset_circuit_model_i (.clk(clk), .rst(rst), .watchdog_overflow_out_n(watchdog_overflow_out_n),
    .chip_reset_out(chip_reset_out), .ovf_len(ovf_len), .rst_len(rst_len), .rst_count(rst_count));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  // One write strobe, called just after an edge
  task automatic wr0(input logic [27:0] a, input logic [1:0] s, input logic [15:0] d);
    bus_addr <= a;
    bus_size <= s;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // Word write followed by one idle edge
  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    wr0(a, wdt_pkg::SIZE_WORD, d);
    @(posedge clk);
  endtask
  // Byte read; data is taken the cycle after the strobe
  task automatic rd(input logic [27:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_size <= wdt_pkg::SIZE_BYTE;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    cmp_count++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      n_fail++;
      $display("mismatch at %0t: got %h outside %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic rchk(input logic [27:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic finish_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, timeout and test sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    rst = 1'b1;
    standby = 1'b0;
    bus_addr = 28'h0;
    bus_size = 2'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 16'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(ctl_rd, 8'h18);
    rchk(cnt_rd, 8'h00);
    rchk(rsc_rd, 8'h1f);
    rchk(rsc_wr, 8'h00);
    $display("done: reset values");
    wr0(ctl_wr, wdt_pkg::SIZE_BYTE, 16'ha538);
    @(posedge clk);
    rchk(ctl_rd, 8'h18);
    wr(ctl_wr, 16'h1238);
    rchk(ctl_rd, 8'h18);
    wr(ctl_wr, 16'ha5b8);
    rchk(ctl_rd, 8'h38);
    wr(ctl_wr, 16'h5a55);
    wr0(ctl_wr, wdt_pkg::SIZE_WORD, 16'ha518);
    rd(cnt_rd, q);
    chk(q, 8'h00);
    $display("done: refused writes");
    for (i = 0; i < 8; i++) begin
      wr(ctl_wr, {8'ha5, 5'h03, i[2:0]});
      wr(ctl_wr, {8'ha5, 5'h07, i[2:0]});
      repeat (4 * div[i] - 1) @(posedge clk);
      rd(cnt_rd, q);
      chk_in(q, 8'h03, 8'h05);
    end
    wr(ctl_wr, 16'ha538);
    // Two passes land the counter write on both prescaler phases
    repeat (2) begin
      wr0(ctl_wr, wdt_pkg::SIZE_WORD, 16'h5a10);
      rd(cnt_rd, q);
      chk(q, 8'h10);
    end
    $display("done: clock select");
    wr(ctl_wr, 16'h5afc);
    for (k = 0; k < 40 && interval_irq !== 1'b1; k++) @(posedge clk);
    chk({7'h0, interval_irq}, 8'h01);
    rchk(ctl_rd, 8'hb8);
    chk({7'h0, watchdog_overflow_out_n}, 8'h01);
    wr(ctl_wr, 16'ha538);
    rchk(ctl_rd, 8'h38);
    chk({7'h0, interval_irq}, 8'h00);
    wr(ctl_wr, 16'ha518);
    $display("done: interval mode");
    for (i = 0; i < 3; i++) begin
      rc = (i == 0) ? 8'h60 : (i == 1) ? 8'h40 : 8'h00; // Enable and type for this pass
      wr(rsc_wr, {8'h5a, rc});
      rchk(rsc_rd, rc | 8'h1f);
      wr(ctl_wr, 16'ha578);
      wr(ctl_wr, 16'h5afe);
      for (k = 0; k < 40 && watchdog_overflow_out_n !== 1'b0; k++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(ovf_len, 8'h04);
      chk(rst_count, (i == 0) ? 8'h01 : 8'h02);
      chk({7'h0, chip_reset_manual}, (i == 0) ? 8'h01 : 8'h00);
      chk({7'h0, interval_irq}, 8'h00);
      rchk(ctl_rd, 8'h18);
      rchk(rsc_rd, rc | 8'h9f);
      wr(rsc_wr, 16'ha500);
      rchk(rsc_rd, rc | 8'h1f);
    end
    chk(rst_len, 8'h08);
    $display("done: watchdog mode");
    wr(rsc_wr, 16'h5a60);
    wr(ctl_wr, 16'ha53b);
    wr(ctl_wr, 16'h5a40);
    standby <= 1'b1;
    repeat (4) @(posedge clk);
    rd(cnt_rd, q);
    chk_in(q, 8'h40, 8'h41);
    standby <= 1'b0;
    @(posedge clk);
    rchk(ctl_rd, 8'h1b);
    rchk(rsc_rd, 8'h1f);
    rchk(cnt_rd, 8'h00);
    $display("done: standby");
    finish_test;
  end
endmodule // tb

/* File: watchdog_interval_timer.sv */
// Eight-bit watchdog / interval timer with keyed word writes, byte reads.
// Assumes one system clock, rst as the external reset pin, and a
// standby level from the power controller.
//
// Overview of operation
// R1: Counter increments on selected tick when enabled
// R2: Wrap FF to 00 raises overflow or interrupt
// R3: Counter cleared on reset or disable, kept in standby
// R4: Flag, mode, enable cleared reset/standby; select reset only
// R5: Interval flag set on wrap, interval mode only
// R6: Interval flag cleared by read one, write zero
// R7: Mode zero interrupts CPU, mode one drives output
// R8: Disabled holds counter at zero, no events
// R9: Reserved bits read back as one
// R10: Clock select picks one of eight dividers
// R11: Reset control set to 1F by pin, standby
// R12: Watchdog flag set on wrap, watchdog mode only
// R13: Watchdog flag cleared by read, write zero
// R14: Enabled chip reset, else counter and control reset
// R15: Type select: zero power-on, one manual reset
// R16: Only word writes accepted, others ignored
// R17: Reads are byte sized
// R18: Shared write address, key picks counter or control
// R19: Reset control keys: clear flag or load enables
// R20: Overflow output 128 cycles, chip reset 512
// R21: Counter write beats a coinciding increment
`timescale 1ns/1ps

module watchdog_interval_timer #(
  parameter int OVF_CYCLES = wdt_pkg::OVF_OUT_CYCLES,
  parameter int RST_CYCLES = wdt_pkg::CHIP_RST_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Power control
  input  wire logic        standby,
  // CPU register bus
  input  wire logic [27:0] bus_addr,
  input  wire logic [1:0]  bus_size,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_wdata,
  output logic [7:0]       bus_rdata,
  // Events
  output logic             interval_irq,
  output logic             watchdog_overflow_out_n,
  output logic             chip_reset_out,
  output logic             chip_reset_manual
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] cnt;       // Tick counter
    logic       ovf;       // Interval overflow flag
    logic       mode;      // One for watchdog mode
    logic       run;       // Timer run enable
    logic [2:0] cks;       // Clock select field
    logic       wflag;     // Watchdog overflow flag
    logic       ren;       // Chip reset enable
    logic       rtype;     // Reset type select
    logic       ovf_arm;   // Interval flag seen as one
    logic       wflag_arm; // Watchdog flag seen as one
    logic [7:0] rdata;     // Read data latch
    logic       irq;       // Interrupt request level
    logic       rst_type;  // Type of last chip reset
  } wdt_s;

  wdt_s st_reg;   // Registered state
  wdt_s st_next;  // Next state

  logic       tick;         // Prescaled counter clock
  logic       word_wr;      // Accepted word write
  logic       cnt_wr;       // Keyed counter write
  logic       ctl_wr;       // Keyed control write
  logic       wclr_wr;      // Keyed flag clear write
  logic       rsten_wr;     // Keyed enable write
  logic       wrap;         // Counter wraps this cycle
  logic       wd_wrap;      // Wrap in watchdog mode
  logic       it_wrap;      // Wrap in interval mode
  logic [7:0] ctl_view;     // Control register as read
  logic [7:0] rsc_view;     // Reset control as read
  logic [7:0] key;          // Upper write byte
  logic [7:0] wbyte;        // Lower write byte
  logic       ovf_active;   // External overflow pulse
  logic       rst_active;   // Chip reset pulse

  // ****************************************
  // Prescaler and pulse generators
  // ****************************************
  wdt_prescaler #(
    .WIDTH (wdt_pkg::PRESCALE_WIDTH)
  ) u_prescaler (
    .clk                (clk),
    .rst                (rst),
    .clock_select_field (st_reg.cks),
    .tick               (tick)
  );

  wdt_pulse_timer #(
    .LENGTH (OVF_CYCLES)
  ) u_ovf_pulse (
    .clk    (clk),
    .rst    (rst),
    .start  (wd_wrap),
    .active (ovf_active)
  );

  wdt_pulse_timer #(
    .LENGTH (RST_CYCLES)
  ) u_rst_pulse (
    .clk    (clk),
    .rst    (rst),
    .start  (wd_wrap & st_reg.ren),
    .active (rst_active)
  );

  // ****************************************
  // Write decode
  // ****************************************
  // Only word writes with a valid key reach the registers
  always_comb begin
    key         = bus_wdata[15:8];
    wbyte       = bus_wdata[7:0];
    word_wr     = bus_wr & (bus_size == wdt_pkg::SIZE_WORD);  // [R16]
    cnt_wr      = word_wr & (bus_addr == wdt_pkg::CTL_WR_ADDR)
                  & (key == wdt_pkg::KEY_5A);                  // [R18]
    ctl_wr      = word_wr & (bus_addr == wdt_pkg::CTL_WR_ADDR)
                  & (key == wdt_pkg::KEY_A5);                  // [R18]
    wclr_wr     = word_wr & (bus_addr == wdt_pkg::RSC_WR_ADDR)
                  & (key == wdt_pkg::KEY_A5) & (wbyte == 8'h00); // [R19]
    rsten_wr    = word_wr & (bus_addr == wdt_pkg::RSC_WR_ADDR)
                  & (key == wdt_pkg::KEY_5A);                  // [R19]
  end

  // ****************************************
  // Overflow detection
  // ****************************************
  // A counter write in the same cycle cancels the increment
  always_comb begin
    wrap    = tick & st_reg.run & ~standby & ~cnt_wr
              & (st_reg.cnt == 8'hff);           // [R2] [R21] [R8]
    wd_wrap = wrap & st_reg.mode;                // [R7]
    it_wrap = wrap & ~st_reg.mode;               // [R7]
  end

  // ****************************************
  // Read views
  // ****************************************
  // Reserved bits always show as one
  always_comb begin
    ctl_view                     = wdt_pkg::CTL_RSVD;      // [R9]
    ctl_view[wdt_pkg::FLAG_BIT]  = st_reg.ovf;
    ctl_view[wdt_pkg::MODE_BIT]  = st_reg.mode;
    ctl_view[wdt_pkg::RUN_BIT]   = st_reg.run;
    ctl_view[wdt_pkg::CKS_MSB:0] = st_reg.cks;
    rsc_view                      = wdt_pkg::RSC_RSVD;     // [R9]
    rsc_view[wdt_pkg::FLAG_BIT]   = st_reg.wflag;
    rsc_view[wdt_pkg::REN_BIT]    = st_reg.ren;
    rsc_view[wdt_pkg::RTYPE_BIT]  = st_reg.rtype;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;

    // Byte reads latch data; reading a set flag arms its clear
    if (bus_rd) begin
      case (bus_addr)
        wdt_pkg::CTL_RD_ADDR: begin
          st_next.rdata = ctl_view;
          if (st_reg.ovf) begin
            st_next.ovf_arm = 1'b1;                // [R6]
          end
        end
        wdt_pkg::CNT_RD_ADDR: begin
          st_next.rdata = st_reg.cnt;
        end
        wdt_pkg::RSC_RD_ADDR: begin
          st_next.rdata = rsc_view;
          if (st_reg.wflag) begin
            st_next.wflag_arm = 1'b1;              // [R13]
          end
        end
        default: begin
          st_next.rdata = 8'h00;                   // Unmapped read
        end
      endcase
    end

    // Counter: write first, else count
    if (cnt_wr) begin
      st_next.cnt = wbyte;                         // [R21]
    end else if (tick & st_reg.run & ~standby) begin
      st_next.cnt = st_reg.cnt + 8'h01;            // [R1]
    end

    // Control register keyed write; flag takes only a zero
    if (ctl_wr) begin
      st_next.mode = wbyte[wdt_pkg::MODE_BIT];
      st_next.run  = wbyte[wdt_pkg::RUN_BIT];
      st_next.cks  = wbyte[wdt_pkg::CKS_MSB:0];    // [R10]
      if (~wbyte[wdt_pkg::FLAG_BIT] & st_reg.ovf_arm) begin
        st_next.ovf     = 1'b0;                    // [R6]
        st_next.ovf_arm = 1'b0;
      end
    end

    // Reset control keyed writes
    if (wclr_wr & st_reg.wflag_arm) begin
      st_next.wflag     = 1'b0;                    // [R13] [R19]
      st_next.wflag_arm = 1'b0;
    end
    if (rsten_wr) begin
      st_next.ren   = wbyte[wdt_pkg::REN_BIT];     // [R19]
      st_next.rtype = wbyte[wdt_pkg::RTYPE_BIT];   // [R15]
    end

    // Interval wrap sets its flag; set beats clear
    if (it_wrap) begin
      st_next.ovf = 1'b1;                          // [R5]
    end

    // Watchdog wrap: flag, reset type, counter and control reset
    if (wd_wrap) begin
      st_next.wflag = 1'b1;                        // [R12]
      if (st_reg.ren) begin
        st_next.rst_type = st_reg.rtype;           // [R15]
      end
      st_next.cnt     = wdt_pkg::CNT_RESET;        // [R14]
      st_next.ovf     = 1'b0;                      // [R14]
      st_next.mode    = 1'b0;
      st_next.run     = 1'b0;
      st_next.cks     = wdt_pkg::CTL_RESET[wdt_pkg::CKS_MSB:0];
      st_next.ovf_arm = 1'b0;
    end

    // Disabled timer holds the counter at zero
    if (~st_next.run & ~standby) begin
      st_next.cnt = wdt_pkg::CNT_RESET;            // [R3] [R8]
    end

    // Standby clears flags and enables, keeps counter and select
    if (standby) begin
      st_next.cnt       = st_reg.cnt;              // [R3]
      st_next.ovf       = 1'b0;                    // [R4]
      st_next.mode      = 1'b0;                    // [R4]
      st_next.run       = 1'b0;                    // [R4]
      st_next.cks       = st_reg.cks;              // [R4]
      st_next.wflag     = 1'b0;                    // [R11]
      st_next.ren       = 1'b0;                    // [R11]
      st_next.rtype     = 1'b0;                    // [R11]
      st_next.ovf_arm   = 1'b0;
      st_next.wflag_arm = 1'b0;
    end

    // Interrupt follows the interval flag
    st_next.irq = st_next.ovf;                     // [R7]
  end

  // ****************************************
  // State register
  // ****************************************
  // External reset pin restores every documented initial value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.cnt      <= wdt_pkg::CNT_RESET;       // [R3]
      st_reg.cks      <= wdt_pkg::CTL_RESET[wdt_pkg::CKS_MSB:0]; // [R4]
      st_reg.wflag    <= wdt_pkg::RSC_RESET[wdt_pkg::FLAG_BIT]; // [R11]
      st_reg.ren      <= wdt_pkg::RSC_RESET[wdt_pkg::REN_BIT];
      st_reg.rtype    <= wdt_pkg::RSC_RESET[wdt_pkg::RTYPE_BIT];
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_rdata               = st_reg.rdata;   // [R17]
  assign interval_irq            = st_reg.irq;
  assign watchdog_overflow_out_n = ~ovf_active;    // [R20]
  assign chip_reset_out          = rst_active;     // [R20] [R14]
  assign chip_reset_manual       = st_reg.rst_type; // [R15]

endmodule // watchdog_interval_timer

/* File: wdt_chk.sv */
// Port checker for the watchdog/interval timer.
// Assumes it is bound into watchdog_interval_timer; one clock, rst async high.
`timescale 1ns/1ps
module wdt_chk #(
  parameter int OVF_CYCLES = 128,
  parameter int RST_CYCLES = 512
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Power and register bus
  input wire logic        standby,
  input wire logic [27:0] bus_addr,
  input wire logic [1:0]  bus_size,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_wdata,
  input wire logic [7:0]  bus_rdata,
  // Events
  input wire logic        interval_irq,
  input wire logic        watchdog_overflow_out_n,
  input wire logic        chip_reset_out,
  input wire logic        chip_reset_manual
);
  // ****************************************
  // Helper state
  // ****************************************
  logic [15:0] lo_cnt;    // Cycles the overflow output has been low
  logic [15:0] hi_cnt;    // Cycles the chip reset has been high
  logic        type_seen; // Last reset type written
  wire ctl_rd  = bus_rd && bus_addr == wdt_pkg::CTL_RD_ADDR;
  wire rsc_rd  = bus_rd && bus_addr == wdt_pkg::RSC_RD_ADDR;
  wire word_wr = bus_wr && bus_size == wdt_pkg::SIZE_WORD;

  // Pulse widths and the written reset type
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_cnt    <= 16'h0;
      hi_cnt    <= 16'h0;
      type_seen <= 1'b0;
    end else begin
      lo_cnt <= watchdog_overflow_out_n ? 16'h0 : lo_cnt + 16'h1;
      hi_cnt <= chip_reset_out ? hi_cnt + 16'h1 : 16'h0;
      if (standby) begin
        type_seen <= 1'b0;
      end else if (word_wr && bus_addr == wdt_pkg::RSC_WR_ADDR && bus_wdata[15:8] == wdt_pkg::KEY_5A) begin
        type_seen <= bus_wdata[wdt_pkg::RTYPE_BIT];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ovf_len: assert property ($rose(watchdog_overflow_out_n) |-> lo_cnt == OVF_CYCLES)
    else $error("overflow pulse length wrong");
  a_ovf_max: assert property (lo_cnt <= OVF_CYCLES)
    else $error("overflow pulse too long");
  a_rst_len: assert property ($fell(chip_reset_out) |-> hi_cnt == RST_CYCLES)
    else $error("chip reset length wrong");
  a_rst_max: assert property (hi_cnt <= RST_CYCLES)
    else $error("chip reset too long");
  a_rst_with_ovf: assert property ($rose(chip_reset_out) |-> $fell(watchdog_overflow_out_n))
    else $error("chip reset without overflow");
  a_rst_type: assert property ($rose(chip_reset_out) |=> chip_reset_manual == type_seen)
    else $error("chip reset type wrong");
  a_rsvd_ctl: assert property (ctl_rd |=> bus_rdata[4:3] == 2'h3)
    else $error("control reserved bits not one");
  a_rsvd_rsc: assert property (rsc_rd |=> bus_rdata[4:0] == 5'h1f)
    else $error("reset control reserved bits not one");
  a_irq_flag: assert property (ctl_rd |=> bus_rdata[7] == $past(interval_irq))
    else $error("interval flag and interrupt differ");
  a_stop_clear: assert property (word_wr && bus_addr == wdt_pkg::CTL_WR_ADDR && bus_wdata[15:8] == wdt_pkg::KEY_A5
    && !bus_wdata[wdt_pkg::RUN_BIT] ##1 bus_rd && bus_addr == wdt_pkg::CNT_RD_ADDR |=> bus_rdata == 8'h00)
    else $error("stopped counter not zero");
  c_irq: cover property ($rose(interval_irq));
  c_ovf: cover property ($fell(watchdog_overflow_out_n));
  c_chip: cover property ($rose(chip_reset_out));
endmodule // wdt_chk

bind watchdog_interval_timer wdt_chk #(.OVF_CYCLES(OVF_CYCLES), .RST_CYCLES(RST_CYCLES)) wdt_chk_i (
  .clk(clk), .rst(rst), .standby(standby), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .interval_irq(interval_irq),
  .watchdog_overflow_out_n(watchdog_overflow_out_n), .chip_reset_out(chip_reset_out),
  .chip_reset_manual(chip_reset_manual));

/* File: wdt_pkg.sv */
// Constants shared by the watchdog/interval timer files.
// Assumes a byte-addressed CPU bus with 28-bit addresses.
package wdt_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [27:0] CTL_WR_ADDR = 28'h5ffffb8; // Shared counter / control write
  localparam logic [27:0] CTL_RD_ADDR = 28'h5ffffb8; // Control/status byte read
  localparam logic [27:0] CNT_RD_ADDR = 28'h5ffffb9; // Counter byte read
  localparam logic [27:0] RSC_WR_ADDR = 28'h5ffffba; // Reset control word write
  localparam logic [27:0] RSC_RD_ADDR = 28'h5ffffbb; // Reset control byte read

  // ****************************************
  // Access sizes and write keys
  // ****************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;   // Byte access
  localparam logic [1:0] SIZE_WORD = 2'h1;   // Word access
  localparam logic [1:0] SIZE_LONG = 2'h2;   // Longword access
  localparam logic [7:0] KEY_5A    = 8'h5a;  // Counter / reset-enable key
  localparam logic [7:0] KEY_A5    = 8'ha5;  // Control / flag-clear key

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FLAG_BIT  = 7;   // Overflow flags in both registers
  localparam int MODE_BIT  = 6;   // Mode select
  localparam int RUN_BIT   = 5;   // Run enable
  localparam int REN_BIT   = 6;   // Chip reset enable
  localparam int RTYPE_BIT = 5;   // Reset type select
  localparam int CKS_MSB   = 2;   // Clock select field top

  // ****************************************
  // Reset values and reserved ones
  // ****************************************
  localparam logic [7:0] CTL_RESET = 8'h18; // Control/status after reset
  localparam logic [7:0] CNT_RESET = 8'h00; // Counter after reset
  localparam logic [7:0] RSC_RESET = 8'h1f; // Reset control after reset
  localparam logic [7:0] CTL_RSVD  = 8'h18; // Bits 4,3 read as one
  localparam logic [7:0] RSC_RSVD  = 8'h1f; // Bits 4..0 read as one

  // ****************************************
  // Timing counts in system clock cycles
  // ****************************************
  localparam int OVF_OUT_CYCLES   = 128; // External overflow pulse length
  localparam int CHIP_RST_CYCLES  = 512; // Internal chip reset length
  localparam int PRESCALE_WIDTH   = 13;  // Enough for divide by 8192

endpackage

/* File: wdt_prescaler.sv */
// Free-running system clock prescaler giving one tick per selected period.
// Assumes a single clock domain; selection comes from the control register.
`timescale 1ns/1ps

module wdt_prescaler #(
  parameter int WIDTH = wdt_pkg::PRESCALE_WIDTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Divider selection
  input  wire logic [2:0] clock_select_field,
  // Counter clock pulse
  output logic            tick
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [WIDTH-1:0] cnt;  // Free-running divider
    logic             tick; // One-cycle tick
  } pre_s;

  pre_s st_reg;   // Registered state
  pre_s st_next;  // Next state

  // Low-bit mask whose all-ones marks the end of one period
  function automatic logic [WIDTH-1:0] period_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    period_mask = WIDTH'(13'h0001);   // Divide by 2
      3'h1:    period_mask = WIDTH'(13'h003f);   // Divide by 64
      3'h2:    period_mask = WIDTH'(13'h007f);   // Divide by 128
      3'h3:    period_mask = WIDTH'(13'h00ff);   // Divide by 256
      3'h4:    period_mask = WIDTH'(13'h01ff);   // Divide by 512
      3'h5:    period_mask = WIDTH'(13'h03ff);   // Divide by 1024
      3'h6:    period_mask = WIDTH'(13'h0fff);   // Divide by 4096
      default: period_mask = WIDTH'(13'h1fff);   // Divide by 8192
    endcase
  endfunction

  // Next-state logic
  always_comb begin
    st_next      = st_reg;
    st_next.cnt  = st_reg.cnt + WIDTH'(1);
    st_next.tick = (st_reg.cnt & period_mask(clock_select_field))
                   == period_mask(clock_select_field); // [R10]
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule // wdt_prescaler

/* File: wdt_pulse_timer.sv */
// Fixed-length pulse generator, retriggered by a one-cycle start.
// Assumes start comes from logic on the same clock.
`timescale 1ns/1ps

module wdt_pulse_timer #(
  parameter int LENGTH = 128
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Trigger and pulse
  input  wire logic start,
  output logic      active
);

  localparam int CW = $clog2(LENGTH) + 1; // Counter width

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [CW-1:0] cnt;    // Cycles left after this one
    logic          active; // Pulse level
  } pulse_s;

  pulse_s st_reg;   // Registered state
  pulse_s st_next;  // Next state

  // Load on start, count down, drop after the last cycle
  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next.cnt    = CW'(LENGTH - 1);
      st_next.active = 1'b1;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CW'(1);
    end else begin
      st_next.active = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign active = st_reg.active;

endmodule // wdt_pulse_timer
